// File: slr_pkg.sv
// Constants shared by the serial line register block
package slr_pkg;
    // ==========================================
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_RSTAT  = 8'h00;
    localparam logic [7:0]  IDX_RXBUF  = 8'h02;
    localparam logic [7:0]  IDX_TSTAT  = 8'h04;
    localparam logic [7:0]  IDX_TXBUF  = 8'h06;
    localparam logic [7:0]  ADDR_RSTAT = {IDX_RSTAT[5:0], 2'b00};
    localparam logic [7:0]  ADDR_RXBUF = {IDX_RXBUF[5:0], 2'b00};
    localparam logic [7:0]  ADDR_TSTAT = {IDX_TSTAT[5:0], 2'b00};
    localparam logic [7:0]  ADDR_TXBUF = {IDX_TXBUF[5:0], 2'b00};
    localparam logic [7:0]  ADDR_CFG   = 8'h20;
    localparam logic [7:0]  ADDR_ISTS  = 8'h24;
    localparam logic [7:0]  ADDR_IMSK  = 8'h28;
    // ==========================================
    // Field positions
    localparam int RS_DONE = 7;
    localparam int RS_IE   = 6;
    localparam int RB_ERR  = 15;
    localparam int RB_OVR  = 14;
    localparam int RB_FRM  = 13;
    localparam int RB_PAR  = 12;
    localparam int TS_RDY  = 7;
    localparam int TS_IE   = 6;
    localparam int TS_BRK  = 0;
    localparam int CF_EIGHT = 16;
    localparam int CF_TWOSTOP = 17;
    localparam int CF_PAREN = 18;
    localparam int CF_ODD   = 19;
    localparam int CF_EXT_BITCLK = 20;
    localparam int CF_BRKHLT = 21;
    localparam int IS_RX    = 0;
    localparam int IS_TX    = 1;
    localparam int IS_FAULT = 2;
    // ==========================================
    // Reset values and counts
    localparam logic [21:0] CFG_RST   = 22'h01_0036;
    localparam logic [2:0]  ISTS_RST  = 3'h0;
    localparam logic [2:0]  IMSK_RST  = 3'h0;
    localparam logic [3:0]  OVS_LAST  = 4'hF;
    localparam logic [3:0]  OVS_MID   = 4'h7;
    // ==========================================
    // State encodings
    typedef enum logic [2:0] {
        SLR_IDLE  = 3'b000,
        SLR_START = 3'b001,
        SLR_DATA  = 3'b010,
        SLR_PAR   = 3'b011,
        SLR_STOP  = 3'b100
    } slr_state_e;
endpackage : slr_pkg

// File: slr_line.sv
// Serial line unit: APB registers, receiver, transmitter, interrupts
// Summary of operation
// - Receive done sets; read buffer clears it
// - Receive enable with done requests interrupt
// - Unused register bits read as zero
// - Error bit is OR of faults
// - Overrun when unread character is overwritten
// - Framing fault on missing stop bit
// - Parity fault; zero without parity
// - Faults held until next character
// - Received data right-justified, high bits zero
// - Transmit ready clears on load, sets later
// - Transmit enable with ready requests interrupt
// - Second line break bit sends space
// - External bit clock replaces internal generator
// - Seven/eight bits, stop, parity configurable
// - One common rate for both directions
// - Console break asserts halt when enabled
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module slr_line #(
    parameter bit SECOND_LINE = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    input  wire logic        external_bit_clock,
    output logic             txd,
    output logic             rx_irq,
    output logic             tx_irq,
    output logic             irq,
    output logic             halt_req
);
    // ==========================================
    // Declarations
    logic [1:0]  rxd_sync_reg, ext_sync_reg;
    logic        ext_prev_reg;
    logic [15:0] div_reg, div_next;
    logic        tick;
    logic [21:0] cfg_reg, cfg_next;
    logic [2:0]  ists_reg, ists_next, imsk_reg, imsk_next;
    logic        rie_reg, rie_next, tie_reg, tie_next, brk_reg, brk_next;
    logic        done_reg, done_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        ovr_reg, ovr_next, frm_reg, frm_next, par_reg, par_next;
    logic [31:0] prdata_reg, prdata_next;
    slr_pkg::slr_state_e rst_reg, rst_next, tst_reg, tst_next;
    logic [3:0]  rcnt_reg, rcnt_next, tcnt_reg, tcnt_next;
    logic [2:0]  ridx_reg, ridx_next, tidx_reg, tidx_next;
    logic [7:0]  rsh_reg, rsh_next, tsh_reg, tsh_next;
    logic        rpar_reg, rpar_next, tstop2_reg, tstop2_next;
    logic        tpar_reg, tpar_next;
    logic [7:0]  hold_reg, hold_next;
    logic        hold_full_reg, hold_full_next, txd_reg, txd_next;
    logic        rx_complete, rd_rxbuf, wr_txbuf, wr_en, rd_setup, mapped;
    logic        eight, paren, odd, exp_par, any_fault;
    logic [7:0]  rx_char;
    logic [2:0]  last_idx;
    logic [31:0] rd_word;

    assign eight    = cfg_reg[slr_pkg::CF_EIGHT];
    assign paren    = cfg_reg[slr_pkg::CF_PAREN];
    assign odd      = cfg_reg[slr_pkg::CF_ODD];
    assign last_idx = eight ? 3'h7 : 3'h6;

    // ==========================================
    // Pin synchronisers and bit clock source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_sync_reg <= 2'h3;
            ext_sync_reg <= 2'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[0], rxd};
            ext_sync_reg <= {ext_sync_reg[0], external_bit_clock};
            ext_prev_reg <= ext_sync_reg[1];
        end
    end

    // Internal divider or external edge gives one shared tick
    always_comb begin
        div_next = (div_reg >= cfg_reg[15:0]) ? 16'h0000 : div_reg + 16'h0001;
        if (cfg_reg[slr_pkg::CF_EXT_BITCLK]) begin
            tick = ext_sync_reg[1] & ~ext_prev_reg;
        end else begin
            tick = (div_reg >= cfg_reg[15:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
        end
    end

    // ==========================================
    // APB decode
    assign mapped   = (paddr == slr_pkg::ADDR_RSTAT) || (paddr == slr_pkg::ADDR_RXBUF) ||
                      (paddr == slr_pkg::ADDR_TSTAT) || (paddr == slr_pkg::ADDR_TXBUF) ||
                      (paddr == slr_pkg::ADDR_CFG)   || (paddr == slr_pkg::ADDR_ISTS) ||
                      (paddr == slr_pkg::ADDR_IMSK);
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~mapped;
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rd_rxbuf = psel & penable & ~pwrite & (paddr == slr_pkg::ADDR_RXBUF);
    assign wr_txbuf = wr_en & (paddr == slr_pkg::ADDR_TXBUF);
    assign prdata   = prdata_reg;

    // Read word; unused bits stay zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            slr_pkg::ADDR_RSTAT: begin
                rd_word[slr_pkg::RS_DONE] = done_reg;
                rd_word[slr_pkg::RS_IE]   = rie_reg;
            end
            slr_pkg::ADDR_RXBUF: begin
                rd_word[slr_pkg::RB_ERR] = ovr_reg | frm_reg | par_reg;
                rd_word[slr_pkg::RB_OVR] = ovr_reg;
                rd_word[slr_pkg::RB_FRM] = frm_reg;
                rd_word[slr_pkg::RB_PAR] = par_reg;
                rd_word[7:0]             = rdata_reg;
            end
            slr_pkg::ADDR_TSTAT: begin
                rd_word[slr_pkg::TS_RDY] = ~hold_full_reg;
                rd_word[slr_pkg::TS_IE]  = tie_reg;
                rd_word[slr_pkg::TS_BRK] = brk_reg;
            end
            slr_pkg::ADDR_CFG:  rd_word[21:0] = cfg_reg;
            slr_pkg::ADDR_ISTS: rd_word[2:0]  = ists_reg;
            slr_pkg::ADDR_IMSK: rd_word[2:0]  = imsk_reg;
            default:            rd_word = 32'h0000_0000;
        endcase
        prdata_next = rd_setup ? rd_word : prdata_reg;
    end

    // Control register writes
    always_comb begin
        cfg_next  = cfg_reg;
        imsk_next = imsk_reg;
        rie_next  = rie_reg;
        tie_next  = tie_reg;
        brk_next  = brk_reg;
        if (wr_en && paddr == slr_pkg::ADDR_CFG)  cfg_next  = pwdata[21:0];
        if (wr_en && paddr == slr_pkg::ADDR_IMSK) imsk_next = pwdata[2:0];
        if (wr_en && paddr == slr_pkg::ADDR_RSTAT) rie_next = pwdata[slr_pkg::RS_IE];
        if (wr_en && paddr == slr_pkg::ADDR_TSTAT) begin
            tie_next = pwdata[slr_pkg::TS_IE];
            brk_next = SECOND_LINE & pwdata[slr_pkg::TS_BRK];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            cfg_reg    <= slr_pkg::CFG_RST;
            imsk_reg   <= slr_pkg::IMSK_RST;
            rie_reg    <= 1'b0;
            tie_reg    <= 1'b0;
            brk_reg    <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            cfg_reg    <= cfg_next;
            imsk_reg   <= imsk_next;
            rie_reg    <= rie_next;
            tie_reg    <= tie_next;
            brk_reg    <= brk_next;
        end
    end

    // ==========================================
    // Receiver
    assign rx_char = eight ? rsh_reg : {1'b0, rsh_reg[7:1]};
    assign exp_par = (^rx_char) ^ odd;
    assign rx_complete = (rst_reg == slr_pkg::SLR_STOP) && tick && (rcnt_reg == slr_pkg::OVS_LAST);
    assign any_fault = ~rxd_sync_reg[1] | (paren & (rpar_reg != exp_par)) |
                       (done_reg & ~rd_rxbuf);

    always_comb begin
        rst_next  = rst_reg;
        rcnt_next = rcnt_reg;
        ridx_next = ridx_reg;
        rsh_next  = rsh_reg;
        rpar_next = rpar_reg;
        unique case (rst_reg)
            slr_pkg::SLR_IDLE: begin
                if (!rxd_sync_reg[1]) begin
                    rst_next  = slr_pkg::SLR_START;
                    rcnt_next = 4'h0;
                end
            end
            slr_pkg::SLR_START: begin
                if (tick) begin
                    rcnt_next = rcnt_reg + 4'h1;
                    if (rcnt_reg == slr_pkg::OVS_MID) begin
                        rcnt_next = 4'h0;
                        ridx_next = 3'h0;
                        rst_next  = rxd_sync_reg[1] ? slr_pkg::SLR_IDLE : slr_pkg::SLR_DATA;
                    end
                end
            end
            slr_pkg::SLR_DATA, slr_pkg::SLR_PAR, slr_pkg::SLR_STOP: begin
                if (tick) begin
                    rcnt_next = rcnt_reg + 4'h1;
                    if (rcnt_reg == slr_pkg::OVS_LAST) begin
                        if (rst_reg == slr_pkg::SLR_DATA) begin
                            rsh_next  = {rxd_sync_reg[1], rsh_reg[7:1]};
                            ridx_next = ridx_reg + 3'h1;
                            if (ridx_reg == last_idx) begin
                                rst_next = paren ? slr_pkg::SLR_PAR : slr_pkg::SLR_STOP;
                            end
                        end else if (rst_reg == slr_pkg::SLR_PAR) begin
                            rpar_next = rxd_sync_reg[1];
                            rst_next  = slr_pkg::SLR_STOP;
                        end else begin
                            rst_next  = slr_pkg::SLR_IDLE;
                        end
                    end
                end
            end
            default: rst_next = slr_pkg::SLR_IDLE;
        endcase
    end

    // Completion loads data and faults; set beats the read clear
    always_comb begin
        done_next  = done_reg;
        rdata_next = rdata_reg;
        ovr_next   = ovr_reg;
        frm_next   = frm_reg;
        par_next   = par_reg;
        if (rd_rxbuf) done_next = 1'b0;
        if (rx_complete) begin
            done_next  = 1'b1;
            rdata_next = rx_char;
            ovr_next   = done_reg & ~rd_rxbuf;
            frm_next   = ~rxd_sync_reg[1];
            par_next   = paren & (rpar_reg != exp_par);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_reg   <= slr_pkg::SLR_IDLE;
            rcnt_reg  <= 4'h0;
            ridx_reg  <= 3'h0;
            rsh_reg   <= 8'h00;
            rpar_reg  <= 1'b0;
            done_reg  <= 1'b0;
            rdata_reg <= 8'h00;
            ovr_reg   <= 1'b0;
            frm_reg   <= 1'b0;
            par_reg   <= 1'b0;
        end else begin
            rst_reg   <= rst_next;
            rcnt_reg  <= rcnt_next;
            ridx_reg  <= ridx_next;
            rsh_reg   <= rsh_next;
            rpar_reg  <= rpar_next;
            done_reg  <= done_next;
            rdata_reg <= rdata_next;
            ovr_reg   <= ovr_next;
            frm_reg   <= frm_next;
            par_reg   <= par_next;
        end
    end

    // ==========================================
    // Transmitter: holding buffer feeds the shifter
    always_comb begin
        tst_next       = tst_reg;
        tcnt_next      = tcnt_reg;
        tidx_next      = tidx_reg;
        tsh_next       = tsh_reg;
        tstop2_next    = tstop2_reg;
        tpar_next      = tpar_reg;
        hold_next      = hold_reg;
        hold_full_next = hold_full_reg;
        txd_next       = 1'b1;
        unique case (tst_reg)
            slr_pkg::SLR_IDLE: begin
                if (hold_full_reg && tick) begin
                    tsh_next       = hold_reg;
                    tpar_next      = (^hold_reg) ^ odd;
                    hold_full_next = 1'b0;
                    tcnt_next      = 4'h0;
                    tst_next       = slr_pkg::SLR_START;
                end
            end
            slr_pkg::SLR_START: txd_next = 1'b0;
            slr_pkg::SLR_DATA:  txd_next = tsh_reg[0];
            slr_pkg::SLR_PAR:   txd_next = tpar_reg;
            slr_pkg::SLR_STOP:  txd_next = 1'b1;
            default:            tst_next = slr_pkg::SLR_IDLE;
        endcase
        if (tst_reg != slr_pkg::SLR_IDLE && tick) begin
            tcnt_next = tcnt_reg + 4'h1;
            if (tcnt_reg == slr_pkg::OVS_LAST) begin
                unique case (tst_reg)
                    slr_pkg::SLR_START: begin
                        tidx_next = 3'h0;
                        tst_next  = slr_pkg::SLR_DATA;
                    end
                    slr_pkg::SLR_DATA: begin
                        tidx_next = tidx_reg + 3'h1;
                        if (tidx_reg == last_idx) begin
                            tst_next = paren ? slr_pkg::SLR_PAR : slr_pkg::SLR_STOP;
                            tstop2_next = cfg_reg[slr_pkg::CF_TWOSTOP];
                        end else begin
                            tsh_next = {1'b0, tsh_reg[7:1]};
                        end
                    end
                    slr_pkg::SLR_PAR: begin
                        tst_next    = slr_pkg::SLR_STOP;
                        tstop2_next = cfg_reg[slr_pkg::CF_TWOSTOP];
                    end
                    default: begin
                        tstop2_next = 1'b0;
                        tst_next    = tstop2_reg ? slr_pkg::SLR_STOP : slr_pkg::SLR_IDLE;
                    end
                endcase
            end
        end
        if (wr_txbuf) begin
            hold_next      = eight ? pwdata[7:0] : {1'b0, pwdata[6:0]};
            hold_full_next = 1'b1;
        end
        if (brk_reg) txd_next = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tst_reg       <= slr_pkg::SLR_IDLE;
            tcnt_reg      <= 4'h0;
            tidx_reg      <= 3'h0;
            tsh_reg       <= 8'h00;
            tstop2_reg    <= 1'b0;
            tpar_reg      <= 1'b0;
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
            txd_reg       <= 1'b1;
        end else begin
            tst_reg       <= tst_next;
            tcnt_reg      <= tcnt_next;
            tidx_reg      <= tidx_next;
            tsh_reg       <= tsh_next;
            tstop2_reg    <= tstop2_next;
            tpar_reg      <= tpar_next;
            hold_reg      <= hold_next;
            hold_full_reg <= hold_full_next;
            txd_reg       <= txd_next;
        end
    end
    assign txd = txd_reg;

    // ==========================================
    // Interrupts and halt request
    always_comb begin
        ists_next = ists_reg;
        if (wr_en && paddr == slr_pkg::ADDR_ISTS) ists_next = ists_reg & ~pwdata[2:0];
        if (rx_complete) ists_next[slr_pkg::IS_RX] = 1'b1;
        if (rx_complete && any_fault) ists_next[slr_pkg::IS_FAULT] = 1'b1;
        if (hold_full_reg && !hold_full_next) ists_next[slr_pkg::IS_TX] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_reg <= slr_pkg::ISTS_RST;
        end else begin
            ists_reg <= ists_next;
        end
    end

    assign rx_irq   = rie_reg & done_reg;
    assign tx_irq   = tie_reg & ~hold_full_reg;
    assign irq      = |(ists_reg & imsk_reg);
    assign halt_req = ~SECOND_LINE & cfg_reg[slr_pkg::CF_BRKHLT] & frm_reg
                      & (rdata_reg == 8'h00);

    // ==========================================
    // Assertions
    property p_done_set;
        @(posedge pclk) disable iff (!presetn) rx_complete |=> done_reg;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");

    property p_done_clr;
        @(posedge pclk) disable iff (!presetn) rd_rxbuf && !rx_complete |=> !done_reg;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");

    property p_rx_irq;
        @(posedge pclk) disable iff (!presetn)
            rx_complete && rie_next |=> rx_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

    property p_rstat_zero;
        @(posedge pclk) disable iff (!presetn)
            rd_setup && paddr == slr_pkg::ADDR_RSTAT |=>
                prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0;
    endproperty
    a_rstat_zero: assert property (p_rstat_zero) else $error("unused bits set");

    property p_err_sum;
        @(posedge pclk) disable iff (!presetn)
            rd_rxbuf |-> prdata[15] == (|prdata[14:12]) && prdata[11:8] == 4'h0;
    endproperty
    a_err_sum: assert property (p_err_sum) else $error("error summary wrong");

    property p_overrun;
        @(posedge pclk) disable iff (!presetn)
            rx_complete && done_reg && !rd_rxbuf |=> ovr_reg;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missing");

    property p_par_off;
        @(posedge pclk) disable iff (!presetn) rx_complete && !paren |=> !par_reg;
    endproperty
    a_par_off: assert property (p_par_off) else $error("parity fault without parity");

    property p_tx_rdy;
        @(posedge pclk) disable iff (!presetn) wr_txbuf |=> !tx_irq && hold_full_reg;
    endproperty
    a_tx_rdy: assert property (p_tx_rdy) else $error("ready not cleared");

    property p_brk;
        @(posedge pclk) disable iff (!presetn) brk_reg [*2] |-> !txd;
    endproperty
    a_brk: assert property (p_brk) else $error("break not spacing");

    property p_irq;
        @(posedge pclk) disable iff (!presetn) rx_complete |=> ists_reg[slr_pkg::IS_RX];
    endproperty
    a_irq: assert property (p_irq) else $error("receive event not recorded");

    c_rx:   cover property (@(posedge pclk) disable iff (!presetn) rx_complete);
    c_ovr:  cover property (@(posedge pclk) disable iff (!presetn) rx_complete && done_reg);
    c_tx:   cover property (@(posedge pclk) disable iff (!presetn) wr_txbuf ##[1:1000] tx_irq);
endmodule : slr_line

// File: slr_term_model.sv
// Serial terminal model facing the line unit
`timescale 1ns/1ps
module slr_term_model #(
    parameter int BT = 320
) (
    output logic      rxd,
    input  wire logic txd
);
    // ==========================================
    // Line idles at mark level
    initial rxd = 1'b1;
    // Frame out LSB first; a low stop level makes a break
    task automatic send(input logic [7:0] d, input int n, input logic pe,
                        input logic pb, input logic stp);
        rxd = 1'b0;
        #(BT);
        for (int i = 0; i < n + pe; i++) begin
            rxd = (i < n) ? d[i] : pb;
            #(BT);
        end
        rxd = stp;
        #(stp ? BT : BT * 3 / 4);
        rxd = 1'b1;
        #(2 * BT);
    endtask : send
    // Sample one eight-bit frame at mid-bit, same rate as sending
    task automatic get(output logic [7:0] d);
        @(negedge txd);
        #(BT * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            d[i] = txd;
            #(BT);
        end
    endtask : get
endmodule : slr_term_model

// File: slr_line_tb.sv
// Self-checking bench for the serial line unit registers
`timescale 1ns/1ps
module slr_line_tb;
    logic        pclk, presetn, psel, penable, pwrite, rxd, txd;
    logic        bit_clk_src = 1'b0;
    logic        pready, pslverr, rx_irq, tx_irq, irq, halt_req;
    logic [7:0]  paddr, b, g1, g2;
    logic [31:0] pwdata, prdata, rdv;
    logic [31:0] seed = 32'h0001478B;
    logic [65:0] expq[$];
    int          n_fail = 0;
    int          checks = 0;
    // ==========================================
    // Design and far-side terminal
    slr_line dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .external_bit_clock(bit_clk_src),
        .txd(txd), .rx_irq(rx_irq), .tx_irq(tx_irq), .irq(irq), .halt_req(halt_req)
    );
    slr_term_model #(.BT(320)) term (.rxd(rxd), .txd(txd));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // External bit clock, one rising edge every two clocks
    always @(posedge pclk) bit_clk_src <= ~bit_clk_src;
    // ==========================================
    // Helpers
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    task automatic cmp_sig(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: line got %h expected %h", $time, g, e);
        end
    endtask : cmp_sig
    task automatic cmp_bus(input logic [32:0] got, input logic [65:0] n);
        if (n[65:33] != 33'h0) begin
            checks++;
            if ((got & n[65:33]) !== n[32:0]) begin
                n_fail++;
                $display("wrong value at %0t: bus got %h expected %h", $time, got, n[32:0]);
            end
        end
    endtask : cmp_bus
    // APB transfer; the expected answer is noted before the request goes out
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] m, input logic [32:0] e);
        @(posedge pclk);
        expq.push_back({m, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {1'b1, 32'hFFFFFFFF}, {1'b0, e});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 33'h0, 33'h0);
    endtask : wr
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // Completed transfers are checked against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready)
            cmp_bus({pslverr, prdata}, expq.pop_front());
    end
    // Watchdog against a hang
    initial begin
        #300_000;
        n_fail++;
        give_verdict();
    end
    // ==========================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(slr_pkg::ADDR_RSTAT, 32'h0);
        rd(slr_pkg::ADDR_RXBUF, 32'h0);
        rd(slr_pkg::ADDR_TSTAT, 32'h80);
        rd(slr_pkg::ADDR_CFG, 32'h00010036);
        bus(1'b0, 8'h30, 32'h0, {1'b1, 32'hFFFFFFFF}, {1'b1, 32'h0});
        $display("test reset done");
        wr(slr_pkg::ADDR_CFG, 32'h00210001);
        wr(slr_pkg::ADDR_RSTAT, 32'h40);
        wr(slr_pkg::ADDR_IMSK, 32'h1);
        b = xs();
        term.send(b, 8, 1'b0, 1'b0, 1'b1);
        rd(slr_pkg::ADDR_RSTAT, 32'hC0);
        cmp_sig(8'(rx_irq), 8'h01);
        cmp_sig(8'(irq), 8'h01);
        rd(slr_pkg::ADDR_RXBUF, {24'h0, b});
        wr(slr_pkg::ADDR_IMSK, 32'h0);
        repeat (2) @(negedge pclk);
        cmp_sig(8'(rx_irq), 8'h00);
        cmp_sig(8'(irq), 8'h00);
        wr(slr_pkg::ADDR_ISTS, 32'h7);
        rd(slr_pkg::ADDR_ISTS, 32'h0);
        $display("test receive done");
        term.send(xs(), 8, 1'b0, 1'b0, 1'b1);
        term.send(8'h00, 8, 1'b0, 1'b0, 1'b0);
        rd(slr_pkg::ADDR_RXBUF, 32'hE000);
        cmp_sig(8'(halt_req), 8'h01);
        rd(slr_pkg::ADDR_RXBUF, 32'hE000);
        b = xs();
        term.send(b, 8, 1'b0, 1'b0, 1'b1);
        rd(slr_pkg::ADDR_RXBUF, {24'h0, b});
        cmp_sig(8'(halt_req), 8'h00);
        $display("test faults done");
        for (int k = 0; k < 4; k++) begin
            b = xs() & 8'h7F;
            wr(slr_pkg::ADDR_CFG, k[1] ? 32'h000C0001 : 32'h00040001);
            term.send(b, 7, 1'b1, ^b ^ k[1] ^ k[0], 1'b1);
            rd(slr_pkg::ADDR_RXBUF, k[0] ? (32'h9000 | b) : {24'h0, b});
        end
        $display("test parity done");
        wr(slr_pkg::ADDR_CFG, 32'h0011FFFF);
        b = xs();
        term.send(b, 8, 1'b0, 1'b0, 1'b1);
        rd(slr_pkg::ADDR_RXBUF, {24'h0, b});
        $display("test external clock done");
        wr(slr_pkg::ADDR_CFG, 32'h00010001);
        wr(slr_pkg::ADDR_TSTAT, 32'h41);
        rd(slr_pkg::ADDR_TSTAT, 32'hC0);
        cmp_sig(8'(tx_irq), 8'h01);
        b = xs();
        fork
            begin
                wr(slr_pkg::ADDR_TXBUF, {24'h0, b});
                wr(slr_pkg::ADDR_TXBUF, {24'h0, ~b});
                rd(slr_pkg::ADDR_TSTAT, 32'h40);
                cmp_sig(8'(tx_irq), 8'h00);
            end
            begin
                term.get(g1);
                term.get(g2);
            end
        join
        cmp_sig(g1, b);
        cmp_sig(g2, ~b);
        rd(slr_pkg::ADDR_TSTAT, 32'hC0);
        wr(slr_pkg::ADDR_CFG, 32'h000E0001);
        b = xs() & 8'h7F;
        fork
            wr(slr_pkg::ADDR_TXBUF, {24'h0, b});
            term.get(g1);
        join
        cmp_sig(g1, {~^b[6:0], b[6:0]});
        $display("test transmit done");
        give_verdict();
    end
endmodule : slr_line_tb
